// >>> design/cocr_pkg.sv
// Constants for the clock output control register bank.
// Assumes byte-wide registers at byte offsets on the serial interface's register port.
package cocr_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] OFF_XO_TRIM_HIGH = 8'h10;
    localparam logic [7:0] OFF_XO_TRIM_LOW = 8'h11;
    localparam logic [7:0] OFF_OUTPUT_DRIVE_CTL = 8'h14;
    localparam logic [7:0] OFF_OUTPUT_POLARITY_CTL = 8'h15;
    localparam logic [7:0] OFF_OUT_DIVIDER_HIGH = 8'h16;
    localparam logic [7:0] OFF_OUT_DIVIDER_LOW = 8'h17;

    // Field positions
    localparam int XO_TRIM_LSB_HI = 1;
    localparam int XO_TRIM_LSB_LO = 0;
    localparam int OUT0_TRISTATE_BIT = 2;
    localparam int OUT_MUTE_BIT = 1;
    localparam int OUT1_POLARITY_FLIP_BIT = 5;
    localparam int OUT0_POLARITY_FLIP_BIT = 4;
    localparam int EDGE_SPEED_HI = 7;
    localparam int EDGE_SPEED_LO = 6;
    localparam int PRESCALE_SEL_BIT = 5;
    localparam int OUT_DIV_MSB_BIT = 0;

    // Reset values
    localparam logic [1:0] XO_TRIM_LSB_RESET = 2'h0;
    localparam logic [7:0] XO_TRIM_MSB_RESET = 8'h80;
    localparam logic [1:0] EDGE_SPEED_RESET = 2'h0;
    localparam logic [7:0] OUT_DIV_LOW_RESET = 8'h20;
    localparam logic OUT_DIV_MSB_RESET = 1'b0;

    // Edge-rate encodings
    localparam logic [1:0] EDGE_FAST = 2'h0;
    localparam logic [1:0] EDGE_SLOW = 2'h2;

    // Divider limits
    localparam logic [8:0] OUT_DIV_MIN = 9'h005;
    localparam logic [8:0] OUT_DIV_MAX = 9'h0ff;

endpackage

// >>> design/cocr_regs.sv
// Register bank for the clock output stage: trim, output control and output divider.
// Assumes a serial-interface front end presenting byte reads and writes synchronous to CLK_I.
`timescale 1ns/100ps
`default_nettype none

module cocr_regs (
    input wire logic CLK_I, // 100 MHz clock
    input wire logic RESET_N_I, // Async reset, active low
    input wire logic WR_EN_I, // Write strobe, one cycle
    input wire logic RD_EN_I, // Read strobe, one cycle
    input wire logic [7:0] ADDR_I, // Register offset
    input wire logic [7:0] WR_DATA_I, // Write byte
    output logic [7:0] RD_DATA_O, // Read byte, registered
    output logic RD_VALID_O, // Read data valid pulse
    output logic [9:0] XO_OFFSET_TRIM_O, // Crystal offset trim
    output logic OUT0_TRISTATE_O, // Output 0 high impedance
    output logic OUT0_OE_O, // Output 0 drive enable
    output logic OUT_MUTE_O, // Output channel mute
    output logic OUT0_POLARITY_FLIP_O, // Invert channel 0
    output logic OUT1_POLARITY_FLIP_O, // Invert channel 1
    output logic [1:0] EDGE_SPEED_SELECT_O, // Edge rate select
    output logic EDGE_SLOW_O, // Slow edges selected
    output logic PRESCALE_DIV5_O, // Prescaler divides by five
    output logic [8:0] OUT_DIV_O, // Applied output divider value
    output logic [9:0] OUT_DIV_RATIO_O, // Applied division ratio
    output logic OUT_DIV_VALID_O // Applied value in legal range
);

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    logic [1:0] xo_trim_lsb;
    logic [7:0] xo_trim_msb;
    logic out0_tristate;
    logic out_mute;
    logic out0_polarity_flip;
    logic out1_polarity_flip;
    logic [1:0] edge_speed_select;
    logic prescale_div5;
    logic out_div_msb;
    logic [7:0] out_div_low_stage;
    logic [8:0] out_div_active;

    wire wr_trim_hi = WR_EN_I && hit(ADDR_I, cocr_pkg::OFF_XO_TRIM_HIGH);
    wire wr_trim_lo = WR_EN_I && hit(ADDR_I, cocr_pkg::OFF_XO_TRIM_LOW);
    wire wr_drive = WR_EN_I && hit(ADDR_I, cocr_pkg::OFF_OUTPUT_DRIVE_CTL);
    wire wr_pol = WR_EN_I && hit(ADDR_I, cocr_pkg::OFF_OUTPUT_POLARITY_CTL);
    wire wr_div_hi = WR_EN_I && hit(ADDR_I, cocr_pkg::OFF_OUT_DIVIDER_HIGH);
    wire wr_div_lo = WR_EN_I && hit(ADDR_I, cocr_pkg::OFF_OUT_DIVIDER_LOW);

    // Only defined fields are stored, so reserved bits cannot reach the outputs
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            xo_trim_lsb <= cocr_pkg::XO_TRIM_LSB_RESET;
            xo_trim_msb <= cocr_pkg::XO_TRIM_MSB_RESET;
        end else begin
            if (wr_trim_hi) begin
                xo_trim_lsb <= WR_DATA_I[cocr_pkg::XO_TRIM_LSB_HI:cocr_pkg::XO_TRIM_LSB_LO];
            end
            if (wr_trim_lo) begin
                xo_trim_msb <= WR_DATA_I;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            out0_tristate <= 1'b0;
            out_mute <= 1'b0;
            out0_polarity_flip <= 1'b0;
            out1_polarity_flip <= 1'b0;
        end else begin
            if (wr_drive) begin
                out0_tristate <= WR_DATA_I[cocr_pkg::OUT0_TRISTATE_BIT];
                out_mute <= WR_DATA_I[cocr_pkg::OUT_MUTE_BIT];
            end
            if (wr_pol) begin
                out0_polarity_flip <= WR_DATA_I[cocr_pkg::OUT0_POLARITY_FLIP_BIT];
                out1_polarity_flip <= WR_DATA_I[cocr_pkg::OUT1_POLARITY_FLIP_BIT];
            end
        end
    end

    // Low byte waits in a stage so a half-written divider never reaches the output
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            edge_speed_select <= cocr_pkg::EDGE_SPEED_RESET;
            prescale_div5 <= 1'b0;
            out_div_msb <= cocr_pkg::OUT_DIV_MSB_RESET;
            out_div_low_stage <= cocr_pkg::OUT_DIV_LOW_RESET;
            out_div_active <= {cocr_pkg::OUT_DIV_MSB_RESET, cocr_pkg::OUT_DIV_LOW_RESET};
        end else begin
            if (wr_div_lo) begin
                out_div_low_stage <= WR_DATA_I;
            end
            if (wr_div_hi) begin
                edge_speed_select <= WR_DATA_I[cocr_pkg::EDGE_SPEED_HI:cocr_pkg::EDGE_SPEED_LO];
                prescale_div5 <= WR_DATA_I[cocr_pkg::PRESCALE_SEL_BIT];
                out_div_msb <= WR_DATA_I[cocr_pkg::OUT_DIV_MSB_BIT];
                // Relies on the host writing the low byte beforehand
                out_div_active <= {WR_DATA_I[cocr_pkg::OUT_DIV_MSB_BIT], out_div_low_stage};
            end
        end
    end

    wire [7:0] rd_trim_hi = {6'h00, xo_trim_lsb};
    wire [7:0] rd_drive = {5'h00, out0_tristate, out_mute, 1'b0};
    wire [7:0] rd_pol = {2'h0, out1_polarity_flip, out0_polarity_flip, 4'h0};
    wire [7:0] rd_div_hi = {edge_speed_select, prescale_div5, 4'h0, out_div_msb};
    wire [7:0] rd_mux =
        hit(ADDR_I, cocr_pkg::OFF_XO_TRIM_HIGH) ? rd_trim_hi :
        hit(ADDR_I, cocr_pkg::OFF_XO_TRIM_LOW) ? xo_trim_msb :
        hit(ADDR_I, cocr_pkg::OFF_OUTPUT_DRIVE_CTL) ? rd_drive :
        hit(ADDR_I, cocr_pkg::OFF_OUTPUT_POLARITY_CTL) ? rd_pol :
        hit(ADDR_I, cocr_pkg::OFF_OUT_DIVIDER_HIGH) ? rd_div_hi :
        hit(ADDR_I, cocr_pkg::OFF_OUT_DIVIDER_LOW) ? out_div_low_stage :
        8'h00;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            RD_DATA_O <= 8'h00;
            RD_VALID_O <= 1'b0;
        end else begin
            RD_VALID_O <= RD_EN_I;
            if (RD_EN_I) begin
                RD_DATA_O <= rd_mux;
            end
        end
    end

    wire [9:0] ratio = {1'b0, out_div_active} + 10'h001;

    assign XO_OFFSET_TRIM_O = {xo_trim_msb, xo_trim_lsb};
    assign OUT0_TRISTATE_O = out0_tristate;
    assign OUT0_OE_O = !out0_tristate;
    assign OUT_MUTE_O = out_mute;
    assign OUT0_POLARITY_FLIP_O = out0_polarity_flip;
    assign OUT1_POLARITY_FLIP_O = out1_polarity_flip;
    assign EDGE_SPEED_SELECT_O = edge_speed_select;
    assign EDGE_SLOW_O = (edge_speed_select == cocr_pkg::EDGE_SLOW);
    assign PRESCALE_DIV5_O = prescale_div5;
    assign OUT_DIV_O = out_div_active;
    assign OUT_DIV_RATIO_O = ratio;
    assign OUT_DIV_VALID_O = (out_div_active >= cocr_pkg::OUT_DIV_MIN) &&
        (out_div_active <= cocr_pkg::OUT_DIV_MAX);

endmodule

`default_nettype wire

// >>> tb/cocr_regs_sva.sv
// Port assertions for the clock output register bank.
// Assumes one clock domain; bound to cocr_regs below.
`timescale 1ns/100ps
`default_nettype none
module cocr_sva (
    input wire logic CLK_I, // clk
    input wire logic RESET_N_I, // rst
    input wire logic WR_EN_I, // wr
    input wire logic [7:0] ADDR_I, // addr
    input wire logic [7:0] WR_DATA_I, // data
    input wire logic OUT0_OE_O, // drive
    input wire logic OUT0_TRISTATE_O, // hi-z
    input wire logic OUT_MUTE_O, // mute
    input wire logic [8:0] OUT_DIV_O, // div
    input wire logic [9:0] OUT_DIV_RATIO_O, // ratio
    input wire logic OUT_DIV_VALID_O // legal
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    wire logic hw = WR_EN_I && ADDR_I == 8'h16;
    wire logic lw = WR_EN_I && ADDR_I == 8'h14;
    oe_tristate_a: assert property (OUT0_OE_O != OUT0_TRISTATE_O) else $error("oe");
    hiz_write_a: assert property (lw |=> OUT0_TRISTATE_O == $past(WR_DATA_I[2])) else $error("hiz");
    mute_write_a: assert property (lw |=> OUT_MUTE_O == $past(WR_DATA_I[1])) else $error("mute");
    div_ratio_a: assert property (OUT_DIV_RATIO_O == OUT_DIV_O + 10'h001) else $error("ratio");
    div_range_a: assert property (OUT_DIV_VALID_O == (OUT_DIV_O >= 9'h005 && OUT_DIV_O <= 9'h0ff))
        else $error("range");
    div_hold_a: assert property (!hw |=> $stable(OUT_DIV_O)) else $error("div moved");
    div_msb_a: assert property (hw |=> OUT_DIV_O[8] == $past(WR_DATA_I[0])) else $error("msb");
    div_low_a: assert property ((WR_EN_I && ADDR_I == 8'h17) ##1 !WR_EN_I ##1 hw
        |=> OUT_DIV_O[7:0] == $past(WR_DATA_I, 3)) else $error("low");
    cover property (hw);
    cover property (lw);
    cover property (!OUT_DIV_VALID_O);
endmodule
bind cocr_regs cocr_sva i_sva (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .WR_EN_I(WR_EN_I),
    .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I), .OUT0_OE_O(OUT0_OE_O),
    .OUT0_TRISTATE_O(OUT0_TRISTATE_O), .OUT_MUTE_O(OUT_MUTE_O), .OUT_DIV_O(OUT_DIV_O),
    .OUT_DIV_RATIO_O(OUT_DIV_RATIO_O), .OUT_DIV_VALID_O(OUT_DIV_VALID_O));
`default_nettype wire

// >>> tb/cocr_host.sv
// Host model issuing byte writes and reads.
// Assumes the caller orders divider bytes; idle bus carries garbage.
`timescale 1ns/100ps
`default_nettype none
module cocr_host (
    input wire logic clk_i, // clock
    output logic wr_o, // write strobe
    output logic rd_o, // read strobe
    output logic [7:0] addr_o, // offset
    output logic [7:0] data_o // byte
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        data_o = 8'h00;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= w;
        rd_o <= !w;
        addr_o <= a;
        data_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        addr_o <= ~a; // Stale value would hide decode faults
        data_o <= ~d;
    endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for cocr_regs.
// Assumes cocr_host drives the register port.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk, rst_n, wr, rd, vld, hiz, oe, mute, f0, f1, slow, p5, ok;
    logic [7:0] addr, wdat, rdat;
    logic [9:0] trim, ratio;
    logic [8:0] div, v, prev;
    logic [1:0] edg;
    logic [7:0] q[$];
    int error_cnt, check_count;
    int cyc = 0;
    logic [7:0] offs [6] = '{8'h10, 8'h11, 8'h14, 8'h15, 8'h16, 8'h17};
    logic [7:0] rstv [6] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h20};
    logic [7:0] mask [6] = '{8'h03, 8'hff, 8'h06, 8'h30, 8'he1, 8'hff};
    logic [8:0] dv [5] = '{9'h004, 9'h005, 9'h0ff, 9'h100, 9'h140};
    logic [7:0] d [6];
    cocr_host i_host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .data_o(wdat));
    cocr_regs i_dut (.CLK_I(clk), .RESET_N_I(rst_n), .WR_EN_I(wr), .RD_EN_I(rd), .ADDR_I(addr),
        .WR_DATA_I(wdat), .RD_DATA_O(rdat), .RD_VALID_O(vld), .XO_OFFSET_TRIM_O(trim),
        .OUT0_TRISTATE_O(hiz), .OUT0_OE_O(oe), .OUT_MUTE_O(mute), .OUT0_POLARITY_FLIP_O(f0),
        .OUT1_POLARITY_FLIP_O(f1), .EDGE_SPEED_SELECT_O(edg), .EDGE_SLOW_O(slow),
        .PRESCALE_DIV5_O(p5), .OUT_DIV_O(div), .OUT_DIV_RATIO_O(ratio), .OUT_DIV_VALID_O(ok));
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        i_host.xfer(1'b0, a, 8'h00);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(negedge clk) begin
        if (vld === 1'b1) chk(10'(rdat), 10'(q.size() ? q.pop_front() : ~rdat));
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        error_cnt = 0;
        check_count = 0;
        rst_n = 1'b0;
        void'($urandom(73604));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) rd_exp(offs[i], rstv[i]);
        rd_exp(8'h12, 8'h00);
        repeat (6) begin
            for (int i = 0; i < 6; i++) begin
                d[i] = 8'($urandom);
                i_host.xfer(1'b1, offs[i], d[i]);
            end
            @(negedge clk);
            chk(trim, {d[1], d[0][1:0]});
            chk(10'({oe, hiz, mute}), 10'({~d[2][2], d[2][2:1]}));
            chk(10'({f1, f0, p5}), 10'({d[3][5:4], d[4][5]}));
            chk(10'({edg, slow}), 10'({d[4][7:6], d[4][7:6] == 2'h2}));
            for (int i = 0; i < 6; i++) rd_exp(offs[i], d[i] & mask[i]);
        end
        i_host.xfer(1'b1, 8'h16, 8'h00);
        prev = {1'b0, d[5]};
        foreach (dv[i]) begin
            v = dv[i];
            i_host.xfer(1'b1, 8'h17, v[7:0]);
            @(negedge clk);
            chk(10'(div), 10'(prev));
            i_host.xfer(1'b1, 8'h16, {7'h00, v[8]});
            @(negedge clk);
            chk({div, ok}, {v, v >= 9'h005 && v <= 9'h0ff});
            chk(ratio, 10'(v) + 10'h001);
            prev = v;
        end
        repeat (2) @(posedge clk);
        summarize();
    end
endmodule
`default_nettype wire
